/* caller_id_line_monitor.sv */
// Hook, monitor ADC and caller data sample path control of the line interface
//
// Overview of operation
// RULE_01 - Monitor enable powers standard on-hook ADC
// RULE_02 - Low-power select plus enable uses low-power ADC
// RULE_03 - Host clears monitor enable before off-hook request
// RULE_04 - Low-power ADC: gain field picks attenuation
// RULE_05 - Coupling reset bit resets ring input coupling
// RULE_06 - Host sequences bits between first and second ring
// RULE_07 - Low-power samples go to serial sample output
// RULE_08 - Host qualifies reversal after 40 ms wait
// RULE_09 - Extra edge during wait means ring
// RULE_10 - Calibration disable skips off-hook calibration
// RULE_11 - Low-power select while off-hook forces on-hook
// RULE_12 - Forced on-hook sends no samples
// RULE_13 - Host checks line voltage for parallel devices
// RULE_14 - Clearing low-power select returns off-hook
// RULE_15 - Return from forced on-hook skips counter
// RULE_16 - Monitor enable then enters fast settle mode
// RULE_17 - Host holds monitor enable 30 ms
// RULE_18 - Normal off-hook blocks data 1548 samples
// RULE_19 - Host mutes upstream and sends acknowledgement
// RULE_20 - Host may clear calibration disable afterwards
// RULE_21 - Decoder filters out DC offset
// RULE_22 - Settle counter of sample ticks gates path
`timescale 1ns/100ps
`default_nettype none
module caller_id_line_monitor #(
    parameter int unsigned sample_divide = line_monitor_pkg::clk_hz
        / line_monitor_pkg::sample_hz_default
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire line_monitor_pkg::control_type control,
    input wire logic [15:0] std_adc_sample,
    input wire logic [15:0] lp_adc_sample,
    input wire logic [15:0] rx_sample,
    output line_monitor_pkg::status_type status,
    output logic [15:0] serial_sample_output,
    output logic sample_valid
);
    import line_monitor_pkg::*;

    control_type ctl_meta;
    control_type ctl;
    control_type ctl_prev;
    hook_state_type state;
    hook_state_type next_state;
    logic tick;
    logic settle_busy;
    logic cal_busy;
    logic forced_return;

    // Host control bits come from another domain: two-stage sync
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ctl_meta <= '0;
            ctl <= '0;
            ctl_prev <= '0;
        end else begin
            ctl_meta <= control;
            ctl <= ctl_meta;
            ctl_prev <= ctl;
        end
    end

    wire logic lp_rise = ctl.low_power_select && !ctl_prev.low_power_select;
    wire logic lp_fall = !ctl.low_power_select && ctl_prev.low_power_select;
    wire logic mon_fall = !ctl.onhook_monitor_enable && ctl_prev.onhook_monitor_enable;

    sample_tick #(
        .divide(sample_divide)
    ) u_tick (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .tick(tick)
    );

    // Hook state machine
    always_comb begin
        next_state = state;
        unique case (state)
            st_onhook: begin
                if (ctl.offhook_request && !ctl.onhook_monitor_enable) begin
                    next_state = st_settle; // see RULE_18
                end
            end
            st_settle: begin
                if (!ctl.offhook_request) begin
                    next_state = st_onhook;
                end else if (!settle_busy && !cal_busy) begin
                    next_state = st_offhook;
                end
            end
            st_offhook: begin
                if (!ctl.offhook_request) begin
                    next_state = st_onhook;
                end else if (lp_rise && !ctl.onhook_monitor_enable) begin
                    next_state = st_forced; // see RULE_11
                end
            end
            st_forced: begin
                if (!ctl.offhook_request) begin
                    next_state = st_onhook;
                end else if (lp_fall) begin
                    next_state = st_offhook; // see RULE_14
                end
            end
            st_fast_settle: begin
                if (!ctl.offhook_request) begin
                    next_state = st_onhook;
                end else if (mon_fall) begin
                    next_state = st_offhook; // see RULE_16
                end
            end
            default: next_state = st_onhook;
        endcase
        // Monitor enable after a forced return enters fast settle
        if (state == st_offhook && forced_return && ctl.onhook_monitor_enable
                && !ctl.low_power_select && ctl.offhook_request) begin
            next_state = st_fast_settle; // see RULE_16
        end
    end

    wire logic enter_normal = (state == st_onhook) && (next_state == st_settle);
    wire logic run_cal = enter_normal && !ctl.auto_calibration_disable; // see RULE_10

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state <= st_onhook;
            forced_return <= 1'b0;
        end else begin
            state <= next_state;
            if (state == st_forced && next_state == st_offhook) begin
                forced_return <= 1'b1; // see RULE_15
            end else if (next_state != st_offhook) begin
                forced_return <= 1'b0;
            end
        end
    end

    // Off-hook settle counter and calibration interval
    settle_counter u_settle (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .load(enter_normal), // see RULE_22
        .length(settle_samples),
        .tick(tick),
        .busy(settle_busy)
    );

    settle_counter u_cal (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .load(run_cal), // see RULE_18
        .length(cal_samples),
        .tick(tick),
        .busy(cal_busy)
    );

    // ADC selection while on-hook
    wire logic onhook = (state == st_onhook);
    wire logic std_on = onhook && ctl.onhook_monitor_enable
        && !ctl.low_power_select; // see RULE_01
    wire logic lp_on = onhook && ctl.onhook_monitor_enable
        && ctl.low_power_select; // see RULE_02
    wire logic blocked = (state == st_settle) || (state == st_forced)
        || (state == st_fast_settle); // see RULE_12

    function automatic logic [2:0] atten_code(input logic [2:0] gain);
        unique case (gain)
            3'h0: atten_code = atten_0db;
            3'h1: atten_code = atten_1db;
            3'h2: atten_code = atten_2p2db;
            3'h3: atten_code = atten_3p5db;
            default: atten_code = atten_5db;
        endcase
    endfunction

    wire logic [2:0] next_atten = lp_on ? atten_code(ctl.receive_gain_field)
        : 3'h0; // see RULE_04
    wire logic [15:0] next_sample = lp_on ? lp_adc_sample
        : std_on ? std_adc_sample : rx_sample; // see RULE_07
    wire logic next_valid = tick && !blocked
        && (std_on || lp_on || state == st_offhook); // see RULE_22

    status_type next_status;
    always_comb begin
        next_status.hook_closed = (state != st_onhook) && (state != st_forced);
        next_status.std_adc_power = std_on;
        next_status.lp_adc_power = lp_on;
        next_status.coupling_reset = ctl.ring_coupling_reset; // see RULE_05
        next_status.calibrating = cal_busy;
        next_status.fast_settle = (state == st_fast_settle);
        next_status.data_blocked = blocked;
        next_status.lp_attenuation = next_atten;
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            status <= '0;
            serial_sample_output <= sample_reset;
            sample_valid <= 1'b0;
        end else begin
            status <= next_status;
            sample_valid <= next_valid;
            if (next_valid) begin
                serial_sample_output <= next_sample;
            end
        end
    end
endmodule // caller_id_line_monitor
`default_nettype wire

/* caller_id_line_monitor_asserts.sv */
// Checker of the line monitor control block
`timescale 1ns/100ps
`default_nettype none
module caller_id_line_monitor_asserts #(
    parameter int unsigned sample_divide = 4
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire line_monitor_pkg::control_type control,
    input wire line_monitor_pkg::status_type status,
    input wire logic sample_valid
);
    import line_monitor_pkg::*;
    int blk;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn)
            blk <= 0;
        else
            blk <= status.data_blocked ? blk + 1 : 0;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    sequence s_held;
        $stable(control)[*5];
    endsequence
    property p_std;
        s_held ##0 control[7:5] == 3'h4 |-> status.std_adc_power && !status.lp_adc_power;
    endproperty
    a_std: assert property (p_std) else $error("standard monitor not powered");
    property p_lp;
        s_held ##0 control[7:5] == 3'h5 |-> status.lp_adc_power && !status.std_adc_power;
    endproperty
    a_lp: assert property (p_lp) else $error("low-power monitor not powered");
    property p_atten;
        s_held ##0 status.lp_adc_power |-> status.lp_attenuation
            == ((control[2:0] > atten_5db) ? atten_5db : control[2:0]);
    endproperty
    a_atten: assert property (p_atten) else $error("wrong attenuation");
    property p_coupling;
        s_held |-> status.coupling_reset == control.ring_coupling_reset;
    endproperty
    a_coupling: assert property (p_coupling) else $error("coupling reset wrong");
    property p_forced;
        s_held ##0 control[7:5] == 3'h3 |-> !status.hook_closed && !sample_valid;
    endproperty
    a_forced: assert property (p_forced) else $error("not forced on-hook");
    property p_blocked;
        status.data_blocked && $past(status.data_blocked) |-> !sample_valid;
    endproperty
    a_blocked: assert property (p_blocked) else $error("sample while blocked");
    property p_settle_len;
        $fell(status.data_blocked) && status.hook_closed && $past(status.hook_closed)
            && !$past(status.fast_settle)
            |-> blk > 1548 * sample_divide - sample_divide - 3
            && blk < 1548 * sample_divide + sample_divide + 3;
    endproperty
    a_settle_len: assert property (p_settle_len) else $error("settle length wrong");
    property p_gap;
        sample_valid |=> !sample_valid [*3];
    endproperty
    a_gap: assert property (p_gap) else $error("samples too close");
    property p_fast;
        status.fast_settle && $past(status.fast_settle) |-> !sample_valid;
    endproperty
    a_fast: assert property (p_fast) else $error("sample in fast settle");
    property p_auto_calibration_disable;
        s_held ##0 control.auto_calibration_disable |-> !status.calibrating;
    endproperty
    a_auto_calibration_disable: assert property (p_auto_calibration_disable) else $error("calibration not skipped");
endmodule // caller_id_line_monitor_asserts
bind caller_id_line_monitor caller_id_line_monitor_asserts #(.sample_divide(sample_divide)) chk (
    .clk_sys(clk_sys), .rstn(rstn), .control(control), .status(status),
    .sample_valid(sample_valid));
`default_nettype wire

/* caller_id_line_monitor_bench.sv */
// Self-checking bench of the line monitor control block
`timescale 1ns/100ps
`default_nettype none
module caller_id_line_monitor_bench;
    import line_monitor_pkg::*;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic load = 1'b0;
    logic [15:0] word = 16'h0;
    logic [15:0] std_word, lp_word, rx_word, sout;
    control_type ctl = '0;
    status_type status;
    logic sample_valid;
    int failures = 0;
    int n_checks = 0;
    int cnt;
    logic [31:0] rs = 32'h32;
    always #2.5 clk_sys = ~clk_sys;
    line_far_end far (.clk_sys(clk_sys), .load(load), .word(word), .std_word(std_word),
        .lp_word(lp_word), .rx_word(rx_word));
    caller_id_line_monitor #(.sample_divide(4)) dut (.clk_sys(clk_sys), .rstn(rstn),
        .control(ctl), .std_adc_sample(std_word), .lp_adc_sample(lp_word),
        .rx_sample(rx_word), .status(status), .serial_sample_output(sout),
        .sample_valid(sample_valid));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic setc(input logic [7:0] v, input int n);
        @(posedge clk_sys);
        ctl <= v;
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic fresh();
        rs = xs(rs);
        @(posedge clk_sys);
        word <= rs[15:0];
        load <= 1'b1;
        @(posedge clk_sys);
        load <= 1'b0;
    endtask
    task automatic take(input logic [15:0] exp, input string what);
        repeat (2) begin
            cnt = 0;
            do begin
                @(posedge clk_sys);
                #1;
                cnt++;
            end while (sample_valid !== 1'b1 && cnt < 50);
            chk(16'(sample_valid), 16'h1, "valid");
        end
        chk(sout, exp, what);
    endtask
    task automatic quiet(input int n);
        cnt = 0;
        repeat (n) begin
            @(posedge clk_sys);
            #1;
            if (sample_valid !== 1'b0) cnt++;
        end
        chk(16'(cnt), 16'h0, "quiet");
    endtask
    initial begin
        repeat (6) @(posedge clk_sys);
        rstn <= 1'b1;
        fresh();
        #1;
        chk(16'(status), 16'h0, "reset");
        setc(8'h80, 8);
        chk(16'(status), 16'h100, "std");
        take(word, "std sample");
        setc(8'h00, 2);
        setc(8'h10, 1);
        setc(8'h30, 1);
        for (int g = 0; g < 8; g++) begin
            fresh();
            setc(8'hb0 | 8'(g), 8);
            chk(16'(status), 16'h0c0 | 16'((g > 4) ? 4 : g), "lp");
            take(word ^ 16'hf0f0, "lp sample");
        end
        setc(8'h00, 8);
        setc(8'h40, 8);
        chk(16'(status), 16'h228, "settle");
        cnt = 6;
        while (status.data_blocked === 1'b1 && cnt < 7000) begin
            @(posedge clk_sys);
            #1;
            cnt++;
        end
        chk(16'(cnt > 6180 && cnt < 6210), 16'h1, "settle length");
        take(~word, "rx sample");
        setc(8'h48, 8);
        setc(8'h68, 8);
        chk(16'(status.hook_closed), 16'h0, "forced");
        quiet(40);
        setc(8'h48, 8);
        chk(16'(status), 16'h200, "return");
        setc(8'hc8, 8);
        chk(16'(status & 10'h210), 16'h210, "fast");
        quiet(40);
        setc(8'h48, 8);
        take(~word, "normal");
        setc(8'h08, 8);
        close_out();
    end
    initial begin
        #(5 * 20000);
        failures++;
        close_out();
    end
endmodule // caller_id_line_monitor_bench
`default_nettype wire

/* line_far_end.sv */
// Far-end line model feeding the monitor and receive converters
`timescale 1ns/100ps
`default_nettype none
module line_far_end (
    input wire logic clk_sys,
    input wire logic load,
    input wire logic [15:0] word,
    output logic [15:0] std_word,
    output logic [15:0] lp_word,
    output logic [15:0] rx_word
);
    always_ff @(posedge clk_sys) begin
        if (load) begin
            std_word <= word;
            lp_word <= word ^ 16'hf0f0;
            rx_word <= ~word;
        end
    end
endmodule // line_far_end
`default_nettype wire

/* line_monitor_pkg.sv */
// Shared constants, states and carrier structs for the line monitor control block
`default_nettype none
package line_monitor_pkg;

    // Clock rate and sample rate divider
    localparam int unsigned clk_hz = 200_000_000;
    localparam int unsigned sample_hz_default = 8000;
    // Off-hook settle interval in sample periods
    localparam logic [11:0] settle_samples = 12'h60c;
    // Calibration length in sample periods
    localparam logic [11:0] cal_samples = 12'h200;
    // Low-power attenuation codes: 0, 1, 2.2, 3.5, 5 dB
    localparam logic [2:0] atten_0db = 3'h0;
    localparam logic [2:0] atten_1db = 3'h1;
    localparam logic [2:0] atten_2p2db = 3'h2;
    localparam logic [2:0] atten_3p5db = 3'h3;
    localparam logic [2:0] atten_5db = 3'h4;
    localparam logic [15:0] sample_reset = 16'h0000;

    typedef enum logic [2:0] {
        st_onhook = 3'b000,
        st_settle = 3'b001,
        st_offhook = 3'b011,
        st_forced = 3'b010,
        st_fast_settle = 3'b110
    } hook_state_type;

    // Host control bits
    typedef struct packed {
        logic onhook_monitor_enable;
        logic offhook_request;
        logic low_power_select;
        logic ring_coupling_reset;
        logic auto_calibration_disable;
        logic [2:0] receive_gain_field;
    } control_type;

    // Status seen by the host
    typedef struct packed {
        logic hook_closed;
        logic std_adc_power;
        logic lp_adc_power;
        logic coupling_reset;
        logic calibrating;
        logic fast_settle;
        logic data_blocked;
        logic [2:0] lp_attenuation;
    } status_type;

endpackage
`default_nettype wire

/* sample_tick.sv */
// Divider producing one-cycle sample-rate enable pulses
`timescale 1ns/100ps
`default_nettype none
module sample_tick #(
    parameter int unsigned divide = 25000
) (
    input wire logic clk_sys,
    input wire logic rstn,
    output logic tick
);
    import line_monitor_pkg::*;
    logic [15:0] count;
    wire logic wrap = (count == 16'(divide - 1));

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            count <= 16'h0000;
            tick <= 1'b0;
        end else begin
            count <= wrap ? 16'h0000 : count + 16'h0001;
            tick <= wrap;
        end
    end
endmodule // sample_tick
`default_nettype wire

/* settle_counter.sv */
// Loadable down counter of sample ticks, busy until it expires
`timescale 1ns/100ps
`default_nettype none
module settle_counter (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic load,
    input wire logic [11:0] length,
    input wire logic tick,
    output logic busy
);
    import line_monitor_pkg::*;
    logic [11:0] remain;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            remain <= 12'h000;
        end else if (load) begin
            remain <= length;
        end else if (tick && remain != 12'h000) begin
            remain <= remain - 12'h001;
        end
    end

    assign busy = (remain != 12'h000);
endmodule // settle_counter
`default_nettype wire
